// ===== block_protector_pkg.sv
// constants, types and helpers shared by the block protector files
// assumes one clock domain (pclk) and a 32-bit apb register port
package block_protector_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CACHE_OFS  = 8'h08;
  localparam int         CTRL_MMU_BIT = 0;
  localparam logic       CTRL_MMU_RST = 1'h0;

  // status field positions
  localparam int ST_LOCK_BIT  = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  localparam int ST_VIOL_BIT  = 3;
  localparam int ST_RANGE_LSB = 4;
  localparam int ST_ADDRESS_PHASE_READY_BIT  = 6;
  localparam int ST_PVIO_BIT  = 7;

  // table geometry: one bit per page, 128 words of 16 bits
  localparam int PAGE_WORDS  = 1024;
  localparam int TABLE_WORDS = 128;

  // i/o command codes
  localparam logic [7:0]  CMD_LOAD_HI = 8'h50;
  localparam logic [7:0]  CMD_READ_HI = 8'hD0;
  localparam logic [15:0] CMD_ENABLE  = 16'h4003;

  // address-phase wait states, 3 bits per clock range,
  // slot 0 fastest range, slot 3 slowest
  localparam logic [11:0] WS_BPU_HIT  = {3'h1, 3'h2, 3'h2, 3'h2};
  localparam logic [11:0] WS_BPU_MISS = {3'h1, 3'h2, 3'h2, 3'h3};
  localparam logic [11:0] WS_MMU_HIT  = {3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [11:0] WS_MMU_MISS = {3'h2, 3'h3, 3'h4, 3'h5};
  localparam logic [2:0]  WS_READ     = 3'h1;
  localparam logic [2:0]  WS_IO       = 3'h2;

  // sram read: drive, two sync cycles, capture
  localparam logic [1:0] RD_CAPTURE = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_END} phase_e;
  typedef enum logic [1:0] {C_NONE, C_LOAD, C_READ, C_ENABLE} cmd_e;

  // pick the wait count for a clock range slot
  function automatic logic [2:0] ws_pick(input logic [11:0] tbl,
                                         input logic [1:0]  idx);
    ws_pick = tbl[{idx, 1'b0} + {2'h0, idx} +: 3];
  endfunction : ws_pick

endpackage : block_protector_pkg

// ===== wait_link.sv
// handshake between the bus sequencer and the wait-state counter
// assumes both ends run on pclk
`timescale 1ns/1ps
interface wait_link;
  logic       load;   // one-cycle start pulse
  logic [2:0] count;  // wait states to insert
  logic       busy;   // high while states remain
  modport ctl (output load, output count, input busy);
  modport cnt (input load, input count, output busy);
endinterface : wait_link

// ===== pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to pclk
`timescale 1ns/1ps
module pin_sync
  import block_protector_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by stage two
    logic [W-1:0] sync;  // safe to use
  } sync_s;

  sync_s r;
  sync_s n;

  // next state
  always_comb
  begin
    n      = r;
    n.meta = din;
    n.sync = r.meta;
  end

  // registers, constant reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign dout = r.sync;

endmodule : pin_sync

// ===== wait_state_counter.sv
// counts inserted address-phase wait states, one per pclk
// assumes load is a single-cycle pulse from the sequencer
`timescale 1ns/1ps
module wait_state_counter
  import block_protector_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  wait_link.cnt     w
);

  typedef struct packed {
    logic [2:0] left;  // states still to insert
  } cnt_s;

  cnt_s r;
  cnt_s n;

  // load wins over the running count
  always_comb
  begin
    n = r;
    if (w.load)
      n.left = w.count;
    else if (r.left != 3'h0)
      n.left = r.left - 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign w.busy = (r.left != 3'h0);

  a_wait_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    (w.load && w.count == 3'h2) |=> w.busy ##1 w.busy ##1 !w.busy)
    else $error("two wait states not counted");

endmodule : wait_state_counter

// ===== block_protector.sv
// block write protector: checks cpu and dma memory writes against a
// protection table in a byte-wide sram, caches one 16-bit word
// assumes bus pins are asynchronous and pass pin_sync first
`timescale 1ns/1ps
module block_protector
  import block_protector_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] information_bus_i,
  output logic      [15:0] information_bus_o,
  output logic             information_bus_oe,
  input  wire logic [7:0]  extended_address,
  input  wire logic        address_strobe,
  input  wire logic        data_strobe_n,
  input  wire logic        bus_busy_n,
  input  wire logic        read_not_write,
  input  wire logic        memory_not_io,
  input  wire logic        dma_select,
  input  wire logic        abort,
  input  wire logic        clock_range_select_a,
  input  wire logic        clock_range_select_b,
  input  wire logic        address_phase_ready_i,
  output logic             address_phase_ready_o,
  output logic             address_phase_ready_oe,
  output logic             data_ready_o,
  output logic             data_ready_oe,
  input  wire logic        protect_violation_n_i,
  output logic             protect_violation_n_o,
  output logic             protect_violation_n_oe,
  output logic             global_write_lock,
  output logic      [7:0]  ram_address,
  input  wire logic [7:0]  ram_data_i,
  output logic      [7:0]  ram_data_o,
  output logic             ram_data_oe,
  output logic             ram_write_n,
  output logic             ram_read_n
);

  localparam int SYNC_W = 43;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] sin;      // raw pins
  logic [SYNC_W-1:0] sout;     // synchronised pins
  logic        s_strba;        // address strobe
  logic        s_strbd_n;      // data strobe, low active
  logic        s_busy_n;       // bus busy, low active
  logic        s_rd;           // read when high
  logic        s_mem;          // memory when high
  logic        s_dma;          // dma requester
  logic        s_abort;        // cycle aborted
  logic [1:0]  s_sel;          // clock range straps
  logic        s_address_phase_ready;         // wired ready level
  logic        s_pvio;         // wired violation level
  logic [15:0] s_ib;           // information bus
  logic [7:0]  s_ext;          // extended address
  logic [7:0]  s_ramd;         // sram data

  assign sin = {address_strobe, data_strobe_n, bus_busy_n,
                read_not_write, memory_not_io, dma_select, abort,
                clock_range_select_a, clock_range_select_b,
                address_phase_ready_i, protect_violation_n_i,
                information_bus_i, extended_address, ram_data_i};

  pin_sync #(.W(SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sin),
    .dout    (sout)
  );

  assign {s_strba, s_strbd_n, s_busy_n, s_rd, s_mem, s_dma, s_abort,
          s_sel, s_address_phase_ready, s_pvio, s_ib, s_ext, s_ramd} = sout;

  //////////////////////////////////////////////////////////////////////
  // wait-state counter

  wait_link wl ();

  wait_state_counter u_wait (
    .pclk    (pclk),
    .presetn (presetn),
    .w       (wl)
  );

  //////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    phase_e      ph;        // bus cycle phase
    logic [1:0]  step;      // sram micro step
    logic        nbyte;     // second byte in progress
    logic        rd_go;     // sram read sequence running
    logic        seq_done;  // address- or data-phase sram work done
    logic        mem;       // memory cycle
    logic        wr;        // write cycle
    cmd_e        cmd;       // decoded i/o command
    logic [6:0]  word;      // table word, msb is requester
    logic [3:0]  bit_idx;   // bit within word
    logic        hit;       // cache hit this cycle
    logic        blk;       // abort seen this cycle
    logic [15:0] cache;     // cached protection word
    logic        valid;     // cache holds a word
    logic [6:0]  tag;       // word held in cache
    logic        lock;      // global write lock
    logic        abort_l;   // latched abort
    logic        viol;      // violation flag
    logic [7:0]  ram_a;
    logic [7:0]  ram_d;
    logic        ram_we;
    logic        ram_oe;
    logic        ram_den;
    logic [15:0] ib_q;      // data returned to cpu
    logic        ib_en;
    logic        rdyd;
    logic        rdyd_en;
    logic        address_phase_ready_hold; // pulls address ready low
    logic        strba_d;   // strobe delayed for edge
    logic        mmu;       // mmu present
    logic [31:0] prdata;
    logic        pslverr;
  } st_s;

  st_s r;
  st_s n;

  //////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    logic       bsel;       // byte of the word on the sram
    logic [1:0] ridx;       // clock range slot
    logic [6:0] w;          // word of a new access
    logic       hit;
    bsel = r.mem ? (r.bit_idx[3] ^ r.nbyte) : r.nbyte;
    ridx = ~s_sel;
    w    = 7'h00;
    hit  = 1'b0;
    n    = r;
    wl.load    = 1'b0;
    wl.count   = 3'h0;
    n.strba_d  = s_strba;

    // apb: decode in setup, write in access
    if (psel && !penable)
    begin
      n.prdata  = 32'h0000_0000;
      n.pslverr = 1'b0;
      case (paddr)
        CTRL_OFS:   n.prdata[CTRL_MMU_BIT] = r.mmu;
        STATUS_OFS:
        begin
          n.prdata[ST_LOCK_BIT]  = r.lock;
          n.prdata[ST_VALID_BIT] = r.valid;
          n.prdata[ST_ABORT_BIT] = r.abort_l;
          n.prdata[ST_VIOL_BIT]  = r.viol;
          n.prdata[ST_RANGE_LSB +: 2] = s_sel;
          n.prdata[ST_ADDRESS_PHASE_READY_BIT]  = s_address_phase_ready;
          n.prdata[ST_PVIO_BIT]  = s_pvio;
        end
        CACHE_OFS:  n.prdata = {8'h00, r.valid, r.tag, r.cache};
        default:    n.pslverr = 1'b1;  // unmapped
      endcase
    end
    if (psel && penable && pwrite && paddr == CTRL_OFS)
      n.mmu = pwdata[CTRL_MMU_BIT];

    // sram read sequence: drive, wait out sync, capture
    if (r.rd_go)
    begin
      if (r.step != RD_CAPTURE)
      begin
        n.ram_a  = {r.word, bsel};
        n.ram_oe = 1'b1;
        n.step   = r.step + 2'h1;
      end
      else
      begin
        n.ram_oe = 1'b0;
        n.step   = 2'h0;
        if (bsel)
          n.cache[15:8] = s_ramd;
        else
          n.cache[7:0]  = s_ramd;
        if (r.nbyte)
        begin  // word complete
          n.rd_go    = 1'b0;
          n.seq_done = 1'b1;
          n.valid    = !(r.blk || s_abort);
          n.tag      = r.word;
        end
        else if (r.mem)
        begin  // first byte holds the page bit
          n.rd_go    = 1'b0;
          n.seq_done = 1'b1;
          n.viol = r.lock | s_ramd[r.bit_idx[2:0]];
        end
        else
          n.nbyte = 1'b1;
      end
    end

    case (r.ph)
      S_IDLE:
      begin
        if (r.strba_d && !s_strba)
        begin  // address latched on strobe fall
          n.ph = S_ADDR;
          n.mem = s_mem;
          n.wr = !s_rd;
          n.step = 2'h0;
          n.nbyte = 1'b0;
          n.blk = 1'b0;
          n.viol = 1'b0;
          n.cmd = C_NONE;
          n.hit = 1'b0;
          n.seq_done = 1'b1;
          n.address_phase_ready_hold = 1'b1;
          wl.load = 1'b1;
          wl.count = WS_IO;
          if (s_mem)
          begin
            if (r.mmu)
            begin
              w = {s_dma, s_ext[5:0]};
              n.bit_idx = {s_ext[7:6], s_ib[5:4]};
            end
            else
            begin
              w = {s_dma, 4'h0, s_ib[1:0]};
              n.bit_idx = s_ib[5:2];
            end
            n.word = w;
            hit = r.valid && !r.abort_l && r.tag == w;
            if (s_rd)
              wl.count = WS_READ;
            else
            begin
              n.hit = hit;
              n.abort_l = 1'b0;
              if (r.mmu)
                wl.count = ws_pick(hit ? WS_MMU_HIT : WS_MMU_MISS,
                                   ridx);
              else
                wl.count = ws_pick(hit ? WS_BPU_HIT : WS_BPU_MISS,
                                   ridx);
              if (hit)  // no fetch needed, index as for a fetch
                n.viol = r.lock | r.cache[n.bit_idx];
              else
              begin  // refill from the sram
                n.valid = 1'b0;
                n.rd_go = 1'b1;
                n.seq_done = 1'b0;
              end
            end
          end
          else if (s_ib == CMD_ENABLE)
          begin
            n.cmd  = C_ENABLE;
            n.lock = 1'b0;
          end
          else if (s_ib[15:8] == CMD_LOAD_HI)
          begin
            n.cmd  = C_LOAD;
            n.word = s_ib[6:0];
          end
          else if (s_ib[15:8] == CMD_READ_HI)
          begin
            n.cmd = C_READ;
            n.word = s_ib[6:0];
            n.valid = 1'b0;
            n.rd_go = 1'b1;
            n.seq_done = 1'b0;
          end
        end
      end
      S_ADDR:
      begin
        if (r.seq_done && !wl.busy)
        begin  // release address ready
          n.address_phase_ready_hold = 1'b0;
          n.ph = S_DATA;
          n.step = 2'h0;
          n.nbyte = 1'b1;
          n.seq_done = !(r.mem && r.wr && !r.hit);
          if (r.cmd == C_LOAD)
            n.nbyte = 1'b0;
        end
      end
      S_DATA:
      begin
        if (!r.seq_done)
        begin  // second byte of a miss
          if (!r.rd_go && !s_strbd_n)
            n.rd_go = 1'b1;
        end
        else if (!r.mem && r.cmd == C_READ)
        begin  // drive the word only once the data strobe is low
          if (!s_strbd_n)
          begin
            n.ib_q  = r.cache;
            n.ib_en = 1'b1;
            n.ph    = S_END;
          end
        end
        else if (!r.mem && r.cmd == C_LOAD)
        begin
          n.rdyd_en = 1'b1;
          n.rdyd    = 1'b0;
          case (r.step)
            2'h0:
            begin
              if (!s_strbd_n)
              begin
                n.cache = s_ib;
                n.step  = 2'h1;
              end
            end
            2'h1:
            begin  // byte on the sram with write strobe
              n.ram_a   = {r.word, r.nbyte};
              n.ram_d   = r.nbyte ? r.cache[15:8] : r.cache[7:0];
              n.ram_den = 1'b1;
              n.ram_we  = !(r.blk || s_abort);
              n.step    = 2'h2;
            end
            default:
            begin
              n.ram_we = 1'b0;
              n.step   = 2'h1;
              n.nbyte  = 1'b1;
              if (r.nbyte)
              begin
                n.rdyd  = 1'b1;
                n.valid = !(r.blk || s_abort);
                n.tag   = r.word;
                n.ph    = S_END;
              end
            end
          endcase
        end
        else
          n.ph = S_END;
      end
      S_END:
      begin
        n.ram_den = 1'b0;
        if (s_strbd_n)
          n.ib_en = 1'b0;
        if (s_busy_n)
        begin  // cycle over
          n.viol    = 1'b0;
          n.rdyd_en = 1'b0;
          n.ph      = S_IDLE;
        end
      end
      default: n.ph = S_IDLE;
    endcase

    // an abort latches and wins over the clear
    if (s_abort)
    begin
      n.abort_l = 1'b1;
      n.blk     = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers: lock set, cache invalid after reset

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r       <= '0;
      r.lock  <= 1'b1;
      r.valid <= 1'b0;
      r.mmu   <= CTRL_MMU_RST;
    end
    else
      r <= n;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign pready  = 1'b1;  // zero-wait slave
  assign prdata  = r.prdata;
  assign pslverr = r.pslverr;
  assign information_bus_o  = r.ib_q;
  assign information_bus_oe = r.ib_en;
  assign address_phase_ready_o  = 1'b0;
  // released as soon as the count and any fetch are over, so the
  // number of held cycles is the larger of the wait states asked for and the fetch
  assign address_phase_ready_oe = r.address_phase_ready_hold &&
                                  (wl.busy || !r.seq_done);
  assign data_ready_o  = r.rdyd;
  assign data_ready_oe = r.rdyd_en;
  // only writes are ever flagged
  assign protect_violation_n_o  = 1'b0;
  assign protect_violation_n_oe = r.viol && r.mem && r.wr;
  assign global_write_lock = r.lock;
  assign ram_address = r.ram_a;
  assign ram_data_o  = r.ram_d;
  assign ram_data_oe = r.ram_den;
  assign ram_write_n = !r.ram_we;
  assign ram_read_n  = !r.ram_oe;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_stays: assert property (
    !global_write_lock |=> !global_write_lock)
    else $error("write lock set again without reset");

  a_read_clean: assert property (
    (r.mem && !r.wr) |-> !(r.viol || protect_violation_n_oe))
    else $error("violation flagged on a read");

  a_locked_viol: assert property (
    (r.ph == S_DATA && r.mem && r.wr && r.lock) |-> r.viol)
    else $error("locked write not flagged");

  a_hit_nofetch: assert property (
    (r.ph == S_ADDR && r.mem && r.wr && r.hit) |-> ram_read_n)
    else $error("sram fetched on a cache hit");

  a_hit_tag: assert property (
    (r.ph == S_ADDR && r.mem && r.wr && r.hit)
    |-> (r.valid && r.tag == r.word))
    else $error("hit without matching tag");

  a_abort_nowrite: assert property (
    r.blk |-> ram_write_n)
    else $error("table written in an aborted cycle");

  a_read_return: assert property (
    information_bus_oe |-> information_bus_o == r.cache)
    else $error("returned word differs from cache");

  a_load_done: assert property (
    (r.ph == S_DATA && r.cmd == C_LOAD && !r.blk && !s_abort &&
     n.ph == S_END)
    |=> (r.valid && r.tag == r.word) ##1 data_ready_o [*1])
    else $error("table load did not update cache");

  a_ready_held: assert property (
    wl.busy |-> address_phase_ready_oe)
    else $error("address ready released too early");

endmodule : block_protector

// ===== lut_sram.sv
// byte-wide protection table sram model, 256 x 8
// assumes address and strobes come from the protector's pclk logic
`timescale 1ns/1ps
module lut_sram (
  input  wire logic [7:0] ram_address,
  input  wire logic [7:0] ram_data_o,
  input  wire logic       ram_data_oe,
  input  wire logic       ram_write_n,
  input  wire logic       ram_read_n,
  output logic      [7:0] ram_data_i
);
  logic [7:0] mem [0:255]; // cpu half then dma half
  ////////////////////////////////////////////////////////////////////
  // latch at the end of the write pulse, when address and data
  // have stood unchanged for the whole pulse
  always @(posedge ram_write_n)
    if (ram_data_oe) mem[ram_address] = ram_data_o;
  // released bus shows the inverse, flipped again on each address change
  always @(ram_read_n or ram_address)
    if (!ram_read_n) ram_data_i = mem[ram_address];
    else ram_data_i = ~ram_data_i;
  // clear table so results never hinge on x
  initial
  begin
    ram_data_i = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
endmodule : lut_sram

// ===== tb_block_protector.sv
// self-checking bench for the block protector
// assumes apb at 125 mhz and one table sram model
`timescale 1ns/1ps
module tb_block_protector
  import block_protector_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, extended_address, ram_address, ram_data_i, ram_data_o;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] information_bus_i, information_bus_o, rd;
  logic        information_bus_oe, address_strobe, data_strobe_n, bus_busy_n;
  logic        read_not_write, memory_not_io, dma_select, abort;
  logic        clock_range_select_a, clock_range_select_b, e, v, dr;
  logic        address_phase_ready_i, address_phase_ready_o;
  logic        address_phase_ready_oe, data_ready_o, data_ready_oe;
  logic        protect_violation_n_i, protect_violation_n_o;
  logic        protect_violation_n_oe, global_write_lock, ram_data_oe;
  logic        ram_write_n, ram_read_n;
  int          fail_count, samples_checked, ws;
  ////////////////////////////////////////////////////////////////////
  // open-collector pins float high unless pulled low
  assign address_phase_ready_i =
    address_phase_ready_oe ? address_phase_ready_o : 1'b1;
  assign protect_violation_n_i =
    protect_violation_n_oe ? protect_violation_n_o : 1'b1;
  block_protector i_block_protector (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .information_bus_i, .information_bus_o, .information_bus_oe,
    .extended_address, .address_strobe, .data_strobe_n, .bus_busy_n,
    .read_not_write, .memory_not_io, .dma_select, .abort,
    .clock_range_select_a, .clock_range_select_b, .address_phase_ready_i,
    .address_phase_ready_o, .address_phase_ready_oe, .data_ready_o,
    .data_ready_oe, .protect_violation_n_i, .protect_violation_n_o,
    .protect_violation_n_oe, .global_write_lock, .ram_address,
    .ram_data_i, .ram_data_o, .ram_data_oe, .ram_write_n, .ram_read_n);
  lut_sram i_lut_sram (.ram_address, .ram_data_o, .ram_data_oe,
    .ram_write_n, .ram_read_n, .ram_data_i);
  ////////////////////////////////////////////////////////////////////
  // 8 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input string n, input logic [31:0] x, y);
    samples_checked++;
    if (y !== x)
    begin
      $display("BAD %s expected %h seen %h", n, x, y);
      fail_count++;
    end
  endtask : chk
  // apb transfer held until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // one processor bus cycle; counts address waits, grabs ib and flag
  task automatic bus(input logic mem, rnw, dma, input logic [15:0] a, d);
    @(posedge pclk);
    {address_strobe, bus_busy_n, memory_not_io} <= {2'b10, mem};
    {read_not_write, dma_select, information_bus_i} <= {rnw, dma, a};
    repeat (4) @(posedge pclk);
    address_strobe <= 1'b0;
    ws = 0;
    // slow misses need the full span of sram reads
    repeat (40) @(posedge pclk) if (address_phase_ready_oe === 1'b1) ws++;
    {data_strobe_n, information_bus_i} <= {1'b0, d};
    rd = 16'h0000;
    dr = 1'b0;
    repeat (30) @(posedge pclk)
    begin
      if (information_bus_oe === 1'b1) rd = information_bus_o;
      if (data_ready_oe === 1'b1 && data_ready_o === 1'b0) dr = 1'b1;
    end
    v = protect_violation_n_oe;
    {data_strobe_n, bus_busy_n} <= 2'b11;
    repeat (6) @(posedge pclk);
  endtask : bus
  ////////////////////////////////////////////////////////////////////
  // reset state and register port
  task automatic t_reset;
    chk("lock_pin", 1, global_write_lock);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("st_lock", 1, q[ST_LOCK_BIT]);
    chk("st_valid", 0, q[ST_VALID_BIT]);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 1, e);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 1, q[CTRL_MMU_BIT]);
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask : t_reset
  // table load, byte order, read back, foreign i/o
  task automatic t_table;
    bus(1'b0, 1'b0, 1'b0, {CMD_LOAD_HI, 8'h00}, 16'hFFFF);
    chk("load_rdyd", 1, dr);
    bus(1'b0, 1'b0, 1'b0, {CMD_LOAD_HI, 8'h40}, 16'h0000);
    bus(1'b0, 1'b0, 1'b0, {CMD_LOAD_HI, 8'h05}, 16'hA55A);
    chk("byte0", 8'h5A, i_lut_sram.mem[8'h0A]);
    chk("byte1", 8'hA5, i_lut_sram.mem[8'h0B]);
    chk("word0", 8'hFF, i_lut_sram.mem[8'h01]);
    bus(1'b0, 1'b1, 1'b0, {CMD_READ_HI, 8'h05}, 16'h0000);
    chk("rd_word", 16'hA55A, rd);
    bus(1'b0, 1'b0, 1'b0, 16'h2003, 16'h0000);
    chk("io_ws", 2, ws);
    chk("io_lock", 1, global_write_lock);
    chk("io_rdyd", 0, dr);
    apb(1'b0, CACHE_OFS, 32'h0);
    chk("cache_reg", {8'h00, 1'b1, 7'h05, 16'hA55A}, q);
  endtask : t_table
  // aborted load leaves the table alone and latches
  task automatic t_abort;
    abort <= 1'b1;
    bus(1'b0, 1'b0, 1'b0, {CMD_LOAD_HI, 8'h05}, 16'h0000);
    chk("ab_byte0", 8'h5A, i_lut_sram.mem[8'h0A]);
    chk("ab_byte1", 8'hA5, i_lut_sram.mem[8'h0B]);
    abort <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("ab_latch", 1, q[ST_ABORT_BIT]);
    chk("ab_valid", 0, q[ST_VALID_BIT]);
  endtask : t_abort
  // locked write flagged, then enable clears lock
  task automatic t_lock;
    bus(1'b1, 1'b0, 1'b1, 16'h0000, 16'h1234);
    chk("lock_vio", 1, v);
    bus(1'b0, 1'b0, 1'b0, CMD_ENABLE, 16'h0000);
    chk("en_ws", 2, ws);
    chk("lock_off", 0, global_write_lock);
  endtask : t_lock
  // miss, hit, range, read and dma cases
  task automatic t_protect;
    bus(1'b1, 1'b0, 1'b0, 16'h0000, 16'h1111);
    chk("miss_vio", 1, v);
    chk("miss_ws", 1, ws > 2);
    chk("mem_rdyd", 0, dr);
    bus(1'b1, 1'b0, 1'b0, 16'h0000, 16'h2222);
    chk("hit_vio", 1, v);
    chk("hit_ws", 2, ws);
    {clock_range_select_a, clock_range_select_b} <= 2'b00;
    bus(1'b1, 1'b0, 1'b0, 16'h0000, 16'h3333);
    chk("slow_ws", 1, ws);
    bus(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk("rd_ws", 1, ws);
    chk("rd_vio", 0, v);
    bus(1'b1, 1'b0, 1'b1, 16'h0000, 16'h4444);
    chk("dma_vio", 0, v);
  endtask : t_protect
  // mmu present: extended bits pick word and bit
  task automatic t_mmu;
    {clock_range_select_a, clock_range_select_b} <= 2'b10;
    extended_address <= 8'h45;
    apb(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, 1'b0, 1'b0, 16'h0000, 16'h5555);
    chk("mmu_miss_vio", 1, v);
    bus(1'b1, 1'b0, 1'b0, 16'h0000, 16'h6666);
    chk("mmu_hit_ws", 3, ws);
    chk("mmu_hit_vio", 1, v);
  endtask : t_mmu
  ////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic give_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // main sequence; straps fastest, upper extended bits grounded
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {address_strobe, data_strobe_n, bus_busy_n} = 3'b011;
    {read_not_write, memory_not_io, dma_select, abort} = 4'h0;
    {information_bus_i, extended_address} = '0;
    {clock_range_select_a, clock_range_select_b} = 2'b11;
    {fail_count, samples_checked} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_table();
    t_abort();
    t_lock();
    t_protect();
    t_mmu();
    give_verdict();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_block_protector
